// ==== fcwt_map.svh ====
// Register offsets, field positions, reset values and timing counts of the front-end block.
`ifndef FCWT_MAP_SVH
`define FCWT_MAP_SVH
`define FCWT_ADDR_EXC 8'h0C
`define FCWT_ADDR_BIAS 8'h0D
`define FCWT_ADDR_PATH 8'h0E
`define FCWT_ADDR_MULT 8'h0F
`define FCWT_ADDR_LAUNCH 8'h10
`define FCWT_RST_EXC 8'hFF
`define FCWT_RST_BIAS 8'h00
`define FCWT_RST_PATH 8'h00
`define FCWT_RST_MULT 8'h00
`define FCWT_RST_LAUNCH 8'h00
`define FCWT_SRC1_MSB 7
`define FCWT_SRC1_LSB 4
`define FCWT_SRC0_MSB 3
`define FCWT_SRC0_LSB 0
`define FCWT_PATH_MSB 5
`define FCWT_PATH_LSB 4
`define FCWT_GAIN_MSB 2
`define FCWT_GAIN_LSB 0
`define FCWT_ROUTE_OFF 4'hF
`define FCWT_ROUTE_LIMIT 4'hA
`define FCWT_DGAIN_MAX 3'h2
`define FCWT_UNIT_PLAIN 16'h0010
`define FCWT_UNIT_SHIFT 4
`endif

// ==== fcwt_pkg.sv ====
// Types shared by the front-end configuration and delay timer block.
package fcwt_pkg;
  // Signal path codes of the path field.
  typedef enum logic [1:0] {
    FCWT_PATH_BUF = 2'h0,
    FCWT_PATH_BYP = 2'h1,
    FCWT_PATH_AMP = 2'h2,
    FCWT_PATH_RSV = 2'h3
  } fcwt_path_t;
  // One-hot states of the delay timer.
  typedef enum logic [1:0] {
    FCWT_T_IDLE = 2'h1,
    FCWT_T_RUN = 2'h2
  } fcwt_tstate_t;
  // Power-down modes as seen on the mode input.
  typedef enum logic [1:0] {
    FCWT_PD_NORMAL = 2'h0,
    FCWT_SLEEP_POWER_DOWN = 2'h1,
    FCWT_STANDBY_POWER_DOWN = 2'h2
  } fcwt_pd_t;
endpackage : fcwt_pkg

// ==== fcwt_top.sv ====
// Front-end routing, path and gain registers with the programmable delay timer.
`timescale 1ns/1ps
`include "fcwt_map.svh"

// Summary of operation
// RULE1: Upper nibble routes source 1, 1010+ off.
// RULE2: Lower nibble routes source 0, 1010+ off.
// RULE3: Each bias bit connects bias to its input.
// RULE4: Path code selects buffer, bypass or amplifier.
// RULE5: Gain code means gain of two^code.
// RULE6: Buffer and bypass paths use digital gain.
// RULE7: Digital gain above 4x is held at 4x.
// RULE8: Delay is ext*16 times base*16 clocks.
// RULE9: Zero extension gives base*16 clocks exactly.
// RULE10: Extension write starts nothing, reads back, resets zero.
// RULE11: Extension value applies to all later delays.
// RULE12: Nonzero launch write starts the countdown.
// RULE13: Launch register reads the live remaining count.
// RULE14: Any write during countdown aborts, keeps contents; the code restarts the countdown instead on a nonzero launch write.
// RULE15: Writing zero to launch starts nothing, sets no done flag and wakes nothing.
// RULE16: Launch write wakes device from sleep or standby.
// RULE17: Bias and excitation on one input exclude each other.
// RULE18: Count once per clock, flag done at zero.
// RULE19: Reserved path and gain bits read zero.
module fcwt_top #(
  parameter int unsigned N_INPUTS = 10,
  parameter int unsigned N_BIAS = 8
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [1:0] pd_mode_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic [N_INPUTS-1:0] src0_en_out,
  output logic [N_INPUTS-1:0] src1_en_out,
  output logic src0_pwr_out,
  output logic src1_pwr_out,
  output logic [N_BIAS-1:0] bias_en_out,
  output logic buf_en_out,
  output logic amp_en_out,
  output logic [2:0] analog_gain_out,
  output logic [2:0] digital_gain_out,
  output logic delay_busy_out,
  output logic delay_done_out,
  output logic wake_out
);

  // Stored configuration registers.
  logic [7:0] exc_ff;
  logic [7:0] nxt_exc;
  logic [7:0] bias_ff;
  logic [7:0] nxt_bias;
  logic [7:0] path_ff;
  logic [7:0] nxt_path;
  logic [7:0] mult_ff;
  logic [7:0] nxt_mult;

  // Delay timer state.
  logic [7:0] launch_ff;
  logic [7:0] nxt_launch;
  logic [15:0] pre_ff;
  logic [15:0] nxt_pre;
  fcwt_pkg::fcwt_tstate_t tstate_ff;
  fcwt_pkg::fcwt_tstate_t nxt_tstate;
  logic done_ff;
  logic nxt_done;
  logic wake_ff;
  logic nxt_wake;
  // Registered copy of the running state so the busy output leaves a flip-flop.
  logic busy_ff;
  logic nxt_busy;

  // Read port state.
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;

  // Decoded front-end controls.
  logic [N_INPUTS-1:0] src0_ff;
  logic [N_INPUTS-1:0] src1_ff;
  logic src0_pwr_ff;
  logic src1_pwr_ff;
  logic buf_ff;
  logic amp_ff;
  logic [2:0] again_ff;
  logic [2:0] dgain_ff;
  logic [N_INPUTS-1:0] nxt_src0;
  logic [N_INPUTS-1:0] nxt_src1;
  logic nxt_src0_pwr;
  logic nxt_src1_pwr;
  logic nxt_buf;
  logic nxt_amp;
  logic [2:0] nxt_again;
  logic [2:0] nxt_dgain;

  // Write strobes per register.
  logic wr_exc;
  logic wr_bias;
  logic wr_path;
  logic wr_mult;
  logic wr_launch;
  // Clocks per base step, taken from the extension register at launch and again at each reload.
  logic [15:0] unit_len;

  assign wr_exc = wr_en_in && (addr_in == `FCWT_ADDR_EXC);
  assign wr_bias = wr_en_in && (addr_in == `FCWT_ADDR_BIAS);
  assign wr_path = wr_en_in && (addr_in == `FCWT_ADDR_PATH);
  assign wr_mult = wr_en_in && (addr_in == `FCWT_ADDR_MULT);
  assign wr_launch = wr_en_in && (addr_in == `FCWT_ADDR_LAUNCH);

  // A zero extension leaves 16 clocks per step, otherwise ext*16*16.
  assign unit_len = (mult_ff == 8'h00) ? `FCWT_UNIT_PLAIN : // RULE9
    {mult_ff, 8'h00}; // RULE8

  // Configuration registers with the bias and excitation exclusion.
  always_comb
  begin
    nxt_exc = exc_ff;
    nxt_bias = bias_ff;
    nxt_path = path_ff;
    nxt_mult = mult_ff;
    if (wr_exc)
    begin
      nxt_exc = wdata_in;
      // Routing a source onto a biased input drops that bias switch.
      for (int i = 0; i < N_BIAS; i++)
      begin
        if (wdata_in[`FCWT_SRC0_MSB:`FCWT_SRC0_LSB] == 4'(i) ||
            wdata_in[`FCWT_SRC1_MSB:`FCWT_SRC1_LSB] == 4'(i))
        begin
          nxt_bias[i] = 1'b0; // RULE17
        end
      end
    end
    if (wr_bias)
    begin
      nxt_bias = wdata_in; // RULE3
      // Biasing an input that carries a source unroutes that source.
      for (int i = 0; i < N_BIAS; i++)
      begin
        if (wdata_in[i] && exc_ff[`FCWT_SRC0_MSB:`FCWT_SRC0_LSB] == 4'(i))
        begin
          nxt_exc[`FCWT_SRC0_MSB:`FCWT_SRC0_LSB] = `FCWT_ROUTE_OFF; // RULE17
        end
        if (wdata_in[i] && exc_ff[`FCWT_SRC1_MSB:`FCWT_SRC1_LSB] == 4'(i))
        begin
          nxt_exc[`FCWT_SRC1_MSB:`FCWT_SRC1_LSB] = `FCWT_ROUTE_OFF; // RULE17
        end
      end
    end
    if (wr_path)
    begin
      // Only the path and gain fields are stored.
      nxt_path = 8'h00; // RULE19
      nxt_path[`FCWT_PATH_MSB:`FCWT_PATH_LSB] = wdata_in[`FCWT_PATH_MSB:`FCWT_PATH_LSB];
      nxt_path[`FCWT_GAIN_MSB:`FCWT_GAIN_LSB] = wdata_in[`FCWT_GAIN_MSB:`FCWT_GAIN_LSB];
    end
    if (wr_mult)
    begin
      nxt_mult = wdata_in; // RULE10
    end
  end

  // Registers the configuration state; the extension holds until rewritten or reset.
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      exc_ff <= `FCWT_RST_EXC;
      bias_ff <= `FCWT_RST_BIAS;
      path_ff <= `FCWT_RST_PATH;
      mult_ff <= `FCWT_RST_MULT;
    end
    else if (ce_in)
    begin
      exc_ff <= nxt_exc;
      bias_ff <= nxt_bias;
      path_ff <= nxt_path;
      mult_ff <= nxt_mult; // RULE11
    end
  end

  // Delay timer: base count steps down once per unit of clocks.
  always_comb
  begin
    nxt_launch = launch_ff;
    nxt_pre = pre_ff;
    nxt_tstate = tstate_ff;
    nxt_done = done_ff;
    nxt_wake = 1'b0;
    unique case (tstate_ff)
      fcwt_pkg::FCWT_T_IDLE:
      begin
        // Idle: nothing counts.
        nxt_pre = pre_ff;
      end
      fcwt_pkg::FCWT_T_RUN:
      begin
        if (wr_en_in)
        begin
          // Any write aborts, keeping the remaining count readable; a nonzero launch write below restarts the countdown instead.
          nxt_tstate = fcwt_pkg::FCWT_T_IDLE; // RULE14
        end
        else if (pre_ff > 16'h0001)
        begin
          nxt_pre = pre_ff - 16'h0001; // RULE18
        end
        else if (launch_ff > 8'h01)
        begin
          // One base step is over; reload the unit.
          nxt_launch = launch_ff - 8'h01; // RULE13
          nxt_pre = unit_len;
        end
        else
        begin
          nxt_launch = 8'h00;
          nxt_pre = 16'h0000;
          nxt_done = 1'b1; // RULE18
          nxt_tstate = fcwt_pkg::FCWT_T_IDLE;
        end
      end
      default:
      begin
        nxt_tstate = fcwt_pkg::FCWT_T_IDLE;
      end
    endcase
    if (wr_launch)
    begin
      nxt_launch = wdata_in;
      if (wdata_in != 8'h00)
      begin
        // A nonzero base starts a fresh countdown.
        nxt_pre = unit_len; // RULE12
        nxt_tstate = fcwt_pkg::FCWT_T_RUN; // RULE12
        nxt_done = 1'b0;
        if (pd_mode_in != fcwt_pkg::FCWT_PD_NORMAL)
        begin
          nxt_wake = 1'b1; // RULE16
        end
      end
      else
      begin
        // Zero starts nothing: no done flag, no wake; a running countdown still aborts.
        nxt_tstate = tstate_ff; // RULE15
        nxt_launch = launch_ff; // RULE15
        if (tstate_ff == fcwt_pkg::FCWT_T_RUN)
        begin
          nxt_tstate = fcwt_pkg::FCWT_T_IDLE; // RULE14
        end
      end
    end
    // Busy follows the next state, so it matches the state flop on every edge.
    nxt_busy = nxt_tstate == fcwt_pkg::FCWT_T_RUN;
  end

  // Registers the timer state.
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      launch_ff <= `FCWT_RST_LAUNCH;
      pre_ff <= 16'h0000;
      tstate_ff <= fcwt_pkg::FCWT_T_IDLE;
      done_ff <= 1'b0;
      wake_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      busy_ff <= nxt_busy;
      launch_ff <= nxt_launch;
      pre_ff <= nxt_pre;
      tstate_ff <= nxt_tstate;
      done_ff <= nxt_done;
      wake_ff <= nxt_wake;
    end
  end

  // Read mux; unmapped offsets read zero.
  always_comb
  begin
    nxt_rvalid = rd_en_in;
    nxt_rdata = rdata_ff;
    if (rd_en_in)
    begin
      unique case (addr_in)
        `FCWT_ADDR_EXC: nxt_rdata = exc_ff;
        `FCWT_ADDR_BIAS: nxt_rdata = bias_ff;
        `FCWT_ADDR_PATH: nxt_rdata = path_ff; // RULE19
        `FCWT_ADDR_MULT: nxt_rdata = mult_ff; // RULE10
        `FCWT_ADDR_LAUNCH: nxt_rdata = launch_ff; // RULE13
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Registers the read answer.
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // Decodes routing, path and gain into switch controls.
  always_comb
  begin
    nxt_src0 = '0;
    nxt_src1 = '0;
    nxt_src0_pwr = exc_ff[`FCWT_SRC0_MSB:`FCWT_SRC0_LSB] < `FCWT_ROUTE_LIMIT; // RULE2
    nxt_src1_pwr = exc_ff[`FCWT_SRC1_MSB:`FCWT_SRC1_LSB] < `FCWT_ROUTE_LIMIT; // RULE1
    for (int i = 0; i < N_INPUTS; i++)
    begin
      nxt_src0[i] = exc_ff[`FCWT_SRC0_MSB:`FCWT_SRC0_LSB] == 4'(i); // RULE2
      nxt_src1[i] = exc_ff[`FCWT_SRC1_MSB:`FCWT_SRC1_LSB] == 4'(i); // RULE1
    end
    nxt_buf = 1'b0;
    nxt_amp = 1'b0;
    nxt_again = 3'h0;
    nxt_dgain = 3'h0;
    unique case (fcwt_pkg::fcwt_path_t'(path_ff[`FCWT_PATH_MSB:`FCWT_PATH_LSB])) // RULE4
      fcwt_pkg::FCWT_PATH_BUF, fcwt_pkg::FCWT_PATH_BYP:
      begin
        nxt_buf = path_ff[`FCWT_PATH_MSB:`FCWT_PATH_LSB] == fcwt_pkg::FCWT_PATH_BUF;
        // Gain is 2^code, applied digitally and capped at 4x.
        nxt_dgain = (path_ff[`FCWT_GAIN_MSB:`FCWT_GAIN_LSB] > `FCWT_DGAIN_MAX) ?
          `FCWT_DGAIN_MAX : path_ff[`FCWT_GAIN_MSB:`FCWT_GAIN_LSB]; // RULE6 RULE7
      end
      fcwt_pkg::FCWT_PATH_AMP:
      begin
        nxt_amp = 1'b1;
        nxt_again = path_ff[`FCWT_GAIN_MSB:`FCWT_GAIN_LSB]; // RULE5
      end
      fcwt_pkg::FCWT_PATH_RSV:
      begin
        // Reserved code: buffer and amplifier both off, unity gain.
        nxt_buf = 1'b0;
      end
    endcase
  end

  // Registers the decoded controls so every output leaves a flip-flop.
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      src0_ff <= '0;
      src1_ff <= '0;
      src0_pwr_ff <= 1'b0;
      src1_pwr_ff <= 1'b0;
      buf_ff <= 1'b0;
      amp_ff <= 1'b0;
      again_ff <= 3'h0;
      dgain_ff <= 3'h0;
    end
    else if (ce_in)
    begin
      src0_ff <= nxt_src0;
      src1_ff <= nxt_src1;
      src0_pwr_ff <= nxt_src0_pwr;
      src1_pwr_ff <= nxt_src1_pwr;
      buf_ff <= nxt_buf;
      amp_ff <= nxt_amp;
      again_ff <= nxt_again;
      dgain_ff <= nxt_dgain;
    end
  end

  assign rdata_out = rdata_ff;
  assign rvalid_out = rvalid_ff;
  assign src0_en_out = src0_ff;
  assign src1_en_out = src1_ff;
  assign src0_pwr_out = src0_pwr_ff;
  assign src1_pwr_out = src1_pwr_ff;
  assign bias_en_out = bias_ff[N_BIAS-1:0];
  assign buf_en_out = buf_ff;
  assign amp_en_out = amp_ff;
  assign analog_gain_out = again_ff;
  assign digital_gain_out = dgain_ff;
  assign delay_busy_out = busy_ff;
  assign delay_done_out = done_ff;
  assign wake_out = wake_ff;

endmodule : fcwt_top

// ==== fcwt_sva.sv ====
// Port checks of the front-end block.
`timescale 1ns/1ps
`include "fcwt_map.svh"
module fcwt_sva #(
  parameter int unsigned N_INPUTS = 10
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [1:0] pd_mode_in,
  input wire logic [N_INPUTS-1:0] src0_en_out,
  input wire logic [N_INPUTS-1:0] src1_en_out,
  input wire logic src0_pwr_out,
  input wire logic src1_pwr_out,
  input wire logic buf_en_out,
  input wire logic amp_en_out,
  input wire logic [2:0] analog_gain_out,
  input wire logic [2:0] digital_gain_out,
  input wire logic delay_busy_out,
  input wire logic delay_done_out,
  input wire logic wake_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  // High for a write taken at the launch offset.
  wire logic go = ce_in && wr_en_in && addr_in == `FCWT_ADDR_LAUNCH;
  src1_route_a: assert property (src1_pwr_out ? $onehot(src1_en_out) : src1_en_out == '0)
    else $error("Source 1 switches wrong.");
  src0_route_a: assert property (src0_pwr_out ? $onehot(src0_en_out) : src0_en_out == '0)
    else $error("Source 0 switches wrong.");
  path_excl_a: assert property (!(buf_en_out && amp_en_out))
    else $error("Buffer and amplifier both on.");
  gain_split_a: assert property (amp_en_out ? digital_gain_out == 3'h0 : analog_gain_out == 3'h0)
    else $error("Gain on the wrong path.");
  dgain_cap_a: assert property (digital_gain_out <= `FCWT_DGAIN_MAX)
    else $error("Digital gain above cap.");
  mult_quiet_a: assert property (ce_in && wr_en_in && addr_in == `FCWT_ADDR_MULT && !delay_busy_out |=> !delay_busy_out)
    else $error("Multiplier write started a delay.");
  launch_go_a: assert property (go && wdata_in != 8'h00 |=> delay_busy_out && !delay_done_out)
    else $error("Launch did not start.");
  zero_nop_a: assert property (go && wdata_in == 8'h00 |=> !delay_busy_out && $stable(delay_done_out) && !wake_out)
    else $error("Zero launch acted.");
  abort_a: assert property (delay_busy_out && ce_in && wr_en_in && addr_in != `FCWT_ADDR_LAUNCH |=> !delay_busy_out)
    else $error("Write did not abort delay.");
  done_end_a: assert property ($fell(delay_busy_out) && !$past(wr_en_in) |-> delay_done_out)
    else $error("Countdown end without done.");
  wake_a: assert property (go && wdata_in != 8'h00 && pd_mode_in != 2'h0 |=> wake_out)
    else $error("Launch did not wake.");
endmodule : fcwt_sva

// ==== fcwt_host.sv ====
// Host model driving the block's strobe register bus.
`timescale 1ns/1ps
module fcwt_host (
  input wire logic clk_in,
  input wire logic rvalid_in,
  input wire logic [7:0] rdata_in,
  output logic ce_out,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  // The bus idles enabled with both strobes low.
  initial
  begin
    ce_out = 1'b1;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // One write, taken at the following rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    wr_en_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(posedge clk_in);
    #1;
    wr_en_out = 1'b0;
    wdata_out = ~d;
  endtask : wr
  // One read; the valid pulse is awaited a bounded time.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int k = 0;
    @(posedge clk_in);
    #1;
    rd_en_out = 1'b1;
    addr_out = a;
    @(posedge clk_in);
    #1;
    rd_en_out = 1'b0;
    while (rvalid_in !== 1'b1 && k < 3)
    begin
      @(posedge clk_in);
      #1;
      k++;
    end
    d = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
  endtask : rd
endmodule : fcwt_host

// ==== testbench.sv ====
// Self-checking bench of the front-end block.
`timescale 1ns/1ps
`include "fcwt_map.svh"
module testbench;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [1:0] pd_mode_in = 2'h0;
  wire logic ce, wr, rd, rv, s0p, s1p, bf, am, busy, done, wake;
  wire logic [7:0] addr, wd, rdata, bias;
  wire logic [9:0] s0, s1;
  wire logic [2:0] ag, dg;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] d;
  logic w;
  fcwt_host fcwt_host_inst (.clk_in(clk_in), .rvalid_in(rv), .rdata_in(rdata), .ce_out(ce),
    .wr_en_out(wr), .rd_en_out(rd), .addr_out(addr), .wdata_out(wd));
  fcwt_top fcwt_top_inst (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce), .wr_en_in(wr),
    .rd_en_in(rd), .addr_in(addr), .wdata_in(wd), .pd_mode_in(pd_mode_in), .rdata_out(rdata),
    .rvalid_out(rv), .src0_en_out(s0), .src1_en_out(s1), .src0_pwr_out(s0p),
    .src1_pwr_out(s1p), .bias_en_out(bias), .buf_en_out(bf), .amp_en_out(am),
    .analog_gain_out(ag), .digital_gain_out(dg), .delay_busy_out(busy),
    .delay_done_out(done), .wake_out(wake));
  // The clock toggles every 2.5 ns, half its 5 ns period.
  always #2.5 clk_in = ~clk_in;
  // Compares one result and reports a mismatch.
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Reads one register and compares its value.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    fcwt_host_inst.rd(a, d);
    chk("rdata", 16'(e), 16'(d));
  endtask : rdchk
  // Waits until decoded outputs have followed a write.
  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask : settle
  // Launches a delay and counts clocks until done rises.
  task automatic delay(input logic [7:0] n, input int unit);
    int c = 0;
    // The write returns just after the edge that takes it, so counting starts there.
    fcwt_host_inst.wr(`FCWT_ADDR_LAUNCH, n);
    while (done !== 1'b1 && c < 9000)
    begin
      @(posedge clk_in);
      #1;
      c++;
    end
    chk("cycles", 16'(n * unit), 16'(c));
    rdchk(`FCWT_ADDR_LAUNCH, 8'h00);
  endtask : delay
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  // A hang is cut short after a fixed number of clocks.
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      conclude();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    rdchk(`FCWT_ADDR_EXC, `FCWT_RST_EXC);
    rdchk(`FCWT_ADDR_MULT, `FCWT_RST_MULT);
    rdchk(8'h11, 8'h00);
    for (int c = 0; c < 16; c++)
    begin
      fcwt_host_inst.wr(`FCWT_ADDR_EXC, {4'(c), 4'(15 - c)});
      settle();
      chk("src1", (c < 10) ? 16'(1 << c) : 16'h0, 16'(s1));
      chk("src0", (c > 5) ? 16'(1 << (15 - c)) : 16'h0, 16'(s0));
      chk("pwr", {c < 10, c > 5}, {s1p, s0p});
    end
    for (int p = 0; p < 4; p++)
      for (int g = 0; g < 8; g++)
      begin
        fcwt_host_inst.wr(`FCWT_ADDR_PATH, 8'hC8 | 8'(p << 4) | 8'(g));
        settle();
        chk("path", {p == 0, p == 2}, {bf, am});
        chk("again", (p == 2) ? 16'(g) : 16'h0, 16'(ag));
        chk("dgain", (p < 2) ? 16'((g > 2) ? 2 : g) : 16'h0, 16'(dg));
      end
    rdchk(`FCWT_ADDR_PATH, 8'h37);
    fcwt_host_inst.wr(`FCWT_ADDR_EXC, 8'hFF);
    fcwt_host_inst.wr(`FCWT_ADDR_BIAS, 8'hA5);
    settle();
    chk("bias", 16'hA5, 16'(bias));
    fcwt_host_inst.wr(`FCWT_ADDR_EXC, 8'hF0);
    rdchk(`FCWT_ADDR_BIAS, 8'hA4);
    fcwt_host_inst.wr(`FCWT_ADDR_BIAS, 8'hA5);
    rdchk(`FCWT_ADDR_EXC, 8'hFF);
    delay(8'h03, 16);
    fcwt_host_inst.wr(`FCWT_ADDR_MULT, 8'h01);
    chk("busy", 16'h0, 16'(busy));
    rdchk(`FCWT_ADDR_MULT, 8'h01);
    delay(8'h02, 256);
    delay(8'h01, 256);
    fcwt_host_inst.wr(`FCWT_ADDR_LAUNCH, 8'h05);
    rdchk(`FCWT_ADDR_LAUNCH, 8'h05);
    fcwt_host_inst.wr(`FCWT_ADDR_EXC, 8'hFF);
    settle();
    chk("abort", 16'h0, {busy, done});
    rdchk(`FCWT_ADDR_LAUNCH, 8'h05);
    fcwt_host_inst.wr(`FCWT_ADDR_LAUNCH, 8'h00);
    settle();
    chk("zero", 16'h0, {busy, done, wake});
    for (int m = 0; m < 3; m++)
    begin
      pd_mode_in = 2'(m);
      fcwt_host_inst.wr(`FCWT_ADDR_LAUNCH, 8'h01);
      w = wake;
      @(posedge clk_in);
      #1;
      w = w | wake;
      chk("wake", 16'(m != 0), 16'(w));
    end
    reset_in = 1'b1;
    settle();
    reset_in = 1'b0;
    rdchk(`FCWT_ADDR_MULT, 8'h00);
    conclude();
  end
endmodule : testbench
bind fcwt_top fcwt_sva #(.N_INPUTS(N_INPUTS)) fcwt_sva_inst (.clk_in(clk_in),
  .reset_in(reset_in), .ce_in(ce_in), .wr_en_in(wr_en_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .pd_mode_in(pd_mode_in), .src0_en_out(src0_en_out),
  .src1_en_out(src1_en_out), .src0_pwr_out(src0_pwr_out), .src1_pwr_out(src1_pwr_out),
  .buf_en_out(buf_en_out), .amp_en_out(amp_en_out), .analog_gain_out(analog_gain_out),
  .digital_gain_out(digital_gain_out), .delay_busy_out(delay_busy_out),
  .delay_done_out(delay_done_out), .wake_out(wake_out));
